// file: src/sdt_channel_core.sv
// sdt_channel_core: one channel of solenoid drive, Avalon-MM register slave
// assumes sense input in 1/128 steps of full-scale current, synchronous to clk
//
// Operation
// [R1] At the fastest chop divider without slew limiting the duty stays within 8% to 92%.
// [R2] At slower dividers without slew limiting the duty stays within 4% to 96% in both modes.
// [R3] With slew limiting, valid only at slower dividers, the duty stays within 7% to 93%.
// [R4] Mode select one gives open-loop voltage PWM in both excite and sustain phases.
// [R5] Voltage mode duty is set in steps of one percent of the chop period.
// [R6] Voltage mode maps code 0 to 0%, low codes to the minimum, high to the maximum, 100+ to full.
// [R7] Mode select zero gives peak-current regulation and is the value after reset.
// [R8] The host uses current regulation only on low-side channels; high-side ones use voltage mode.
// [R9] Current mode takes the active level code as a 7-bit current target.
// [R10] Current mode codes 1 to 126 give a peak threshold of code/128 of full scale.
// [R11] Current mode code 0 holds high side on and low side off for the phase.
// [R12] Current mode code 127 holds low side on and high side off for the phase.
// [R13] Current mode regulates period by period from the internal sense, no external resistor.
// [R14] The oscillator runs at 100 or 80 kHz by rate select and is divided by 1 to 4 per channel.
// [R15] The excite code applies first, then the sustain code after the excite time until deactivation.
// [R16] Current mode turns low side on at period start and hands over to high side at the threshold.
// [R17] New codes, mode and divider take effect only at the start of the next chop period.
//
// The Avalon-MM register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module sdt_channel_core #(
    parameter int EXCITE_UNIT = sdt_pkg::EXCITE_UNIT_PERIODS
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // current sense, 128 = full scale
    input wire logic [7:0] senseCurrent,
    // bridge drive
    output logic lowSideOn,
    output logic highSideOn,
    output logic [6:0] peakCurrentThreshold
);
    import sdt_pkg::*;

    sdt_map_if mapIf ();

    // software settings
    logic active_r;
    logic modeSel_r;
    logic slewEn_r;
    logic [1:0] divSel_r;
    logic oscRate_r;
    logic [6:0] exciteCode_r;
    logic [6:0] sustainCode_r;
    logic [7:0] exciteTime_r;
    // bus handshake
    logic req;
    logic ack_r;
    logic wrTake;
    // period timing
    logic tick;
    logic [6:0] slot_r;
    logic [1:0] sub_r;
    logic lastSub;
    logic periodEnd;
    logic periodStart;
    // phase
    sdt_phase_t state_r;
    sdt_phase_t stateNxt;
    logic [13:0] exciteLeft_r;
    // values latched for the running period
    logic modeLat_r;
    logic [1:0] divLat_r;
    logic [6:0] duty_r;
    logic [6:0] dMin_r;
    logic [6:0] dMax_r;
    logic [6:0] thr_r;
    logic holdHigh_r;
    logic holdLow_r;
    logic trip_r;
    logic lsCalc;

    sdt_osc_tick u_tick (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .rateSel(oscRate_r), // R14
        .tick(tick)
    );

    sdt_duty_map u_map (
        .m(mapIf.mapper)
    );

    // one wait state: data is prepared while waitrequest is high
    assign req = avs_read || avs_write;
    assign avs_waitrequest = req && !ack_r;
    assign wrTake = ce && avs_write && ack_r;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ack_r <= 1'b0;
        else if (ce)
            ack_r <= req && !ack_r;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            avs_readdata <= '0;
        else if (ce && avs_read && !ack_r)
        begin
            avs_readdata <= '0;
            case (avs_address)
                OFS_CTRL:
                begin
                    avs_readdata[CTRL_ACTIVE] <= active_r;
                    avs_readdata[CTRL_MODE] <= modeSel_r;
                    avs_readdata[CTRL_SLEW] <= slewEn_r;
                    avs_readdata[CTRL_DIV_LO +: 2] <= divSel_r;
                    avs_readdata[CTRL_RATE] <= oscRate_r;
                end
                OFS_LEVEL:
                begin
                    avs_readdata[LVL_EXCITE_LO +: 7] <= exciteCode_r;
                    avs_readdata[LVL_SUSTAIN_LO +: 7] <= sustainCode_r;
                    avs_readdata[LVL_TIME_LO +: 8] <= exciteTime_r;
                end
                OFS_STATUS:
                begin
                    avs_readdata[6:0] <= duty_r;
                    avs_readdata[STS_LS] <= lowSideOn;
                    avs_readdata[STS_HS] <= highSideOn;
                    avs_readdata[STS_PHASE_LO +: 3] <= state_r;
                    avs_readdata[STS_TRIP] <= trip_r;
                end
                OFS_THRESH: avs_readdata[6:0] <= thr_r;
                default: avs_readdata <= '0;
            endcase
        end
    end

    // control register; writes to read-only or unmapped words are dropped
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            active_r <= 1'b0;
            modeSel_r <= 1'b0; // R7
            slewEn_r <= 1'b0;
            divSel_r <= RST_DIV;
            oscRate_r <= 1'b0;
        end
        else if (wrTake && avs_address == OFS_CTRL && avs_byteenable[0])
        begin
            active_r <= avs_writedata[CTRL_ACTIVE];
            modeSel_r <= avs_writedata[CTRL_MODE];
            slewEn_r <= avs_writedata[CTRL_SLEW];
            divSel_r <= avs_writedata[CTRL_DIV_LO +: 2];
            oscRate_r <= avs_writedata[CTRL_RATE];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            exciteCode_r <= RST_CODE;
            sustainCode_r <= RST_CODE;
            exciteTime_r <= RST_TIME;
        end
        else if (wrTake && avs_address == OFS_LEVEL)
        begin
            if (avs_byteenable[0])
                exciteCode_r <= avs_writedata[LVL_EXCITE_LO +: 7];
            if (avs_byteenable[1])
                sustainCode_r <= avs_writedata[LVL_SUSTAIN_LO +: 7];
            if (avs_byteenable[2])
                exciteTime_r <= avs_writedata[LVL_TIME_LO +: 8];
        end
    end

    // chop period: 100 slots, each 1..4 oscillator ticks long
    assign lastSub = (sub_r == 2'(SUB_TOP - divLat_r)); // R14
    assign periodEnd = ce && tick && lastSub && (slot_r == SLOT_LAST);
    assign periodStart = ce && active_r && ((state_r == SDT_IDLE) || periodEnd);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            slot_r <= '0;
            sub_r <= '0;
        end
        else if (ce)
        begin
            if (state_r == SDT_IDLE || !active_r)
            begin
                slot_r <= '0;
                sub_r <= '0;
            end
            else if (tick)
            begin
                if (lastSub)
                begin
                    sub_r <= '0;
                    slot_r <= (slot_r == SLOT_LAST) ? 7'h00 : 7'(slot_r + 7'h01); // R5
                end
                else
                    sub_r <= 2'(sub_r + 2'h1);
            end
        end
    end

    // phase sequencing
    always_comb
    begin
        stateNxt = state_r;
        case (state_r)
            SDT_IDLE:
                if (active_r)
                    stateNxt = (exciteTime_r == EXCITE_NONE) ? SDT_SUSTAIN : SDT_EXCITE; // R15
            SDT_EXCITE:
                if (!active_r)
                    stateNxt = SDT_IDLE;
                else if (periodEnd && exciteTime_r != EXCITE_ENDLESS && exciteLeft_r <= 14'h0001)
                    stateNxt = SDT_SUSTAIN; // R15
            SDT_SUSTAIN:
                if (!active_r)
                    stateNxt = SDT_IDLE;
            default: stateNxt = SDT_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            state_r <= SDT_IDLE;
        else if (ce)
            state_r <= stateNxt;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            exciteLeft_r <= '0;
        else if (ce)
        begin
            if (state_r == SDT_IDLE)
                exciteLeft_r <= 14'(exciteTime_r * EXCITE_UNIT);
            else if (periodEnd && exciteLeft_r != 14'h0000)
                exciteLeft_r <= 14'(exciteLeft_r - 14'h0001);
        end
    end

    // the mapper sees the code of the phase that the next period belongs to
    assign mapIf.code = (stateNxt == SDT_SUSTAIN) ? sustainCode_r : exciteCode_r; // R15
    assign mapIf.voltMode = modeSel_r; // R4
    assign mapIf.slewEn = slewEn_r;
    assign mapIf.divSel = divSel_r;

    // settings change only here, so a running period is never cut short
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            modeLat_r <= 1'b0;
            divLat_r <= RST_DIV;
            duty_r <= DUTY_ZERO;
            dMin_r <= DUTY_MIN_FAST;
            dMax_r <= DUTY_MAX_FAST;
            thr_r <= CODE_ZERO;
            holdHigh_r <= 1'b0;
            holdLow_r <= 1'b0;
        end
        else if (periodStart)
        begin
            modeLat_r <= mapIf.voltMode; // R17
            divLat_r <= mapIf.divSel; // R17
            duty_r <= mapIf.duty; // R17
            dMin_r <= mapIf.dutyMin;
            dMax_r <= mapIf.dutyMax;
            thr_r <= mapIf.thresh; // R10
            holdHigh_r <= mapIf.holdHigh;
            holdLow_r <= mapIf.holdLow;
        end
    end

    // peak detect; a fresh period always starts untripped
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            trip_r <= 1'b0;
        else if (ce)
        begin
            if (periodStart)
                trip_r <= 1'b0; // R16
            else if (state_r != SDT_IDLE && !modeLat_r && lowSideOn
                     && senseCurrent >= {1'b0, thr_r})
                trip_r <= 1'b1; // R13
        end
    end

    always_comb
    begin
        if (state_r == SDT_IDLE)
            lsCalc = 1'b0;
        else if (holdLow_r)
            lsCalc = 1'b1; // R12
        else if (holdHigh_r)
            lsCalc = 1'b0; // R11
        else if (modeLat_r)
            lsCalc = (slot_r < duty_r); // R4
        else
            lsCalc = (slot_r < dMin_r) || (!trip_r && slot_r < dMax_r); // R16
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lowSideOn <= 1'b0;
            highSideOn <= 1'b0;
            peakCurrentThreshold <= CODE_ZERO;
        end
        else if (ce)
        begin
            lowSideOn <= lsCalc;
            highSideOn <= (state_r != SDT_IDLE) && !lsCalc;
            peakCurrentThreshold <= thr_r; // R10
        end
    end

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_period_begin;
        periodStart && !mapIf.voltMode && !mapIf.holdHigh && !mapIf.holdLow;
    endsequence

    sequence s_low_side_leads;
        ce [*2] ##0 lowSideOn && !highSideOn;
    endsequence

    property p_fast_limits;
        (state_r != SDT_IDLE && divLat_r == DIV_FASTEST)
            |-> dMin_r == 7'h08 && dMax_r == 7'h5C;
    endproperty
    a_fast_limits: assert property (p_fast_limits) else $error("fast divider limits wrong"); // R1

    property p_slow_limits;
        (periodStart && mapIf.divSel != DIV_FASTEST && !mapIf.slewEn)
            |=> dMin_r == 7'h04 && dMax_r == 7'h60;
    endproperty
    a_slow_limits: assert property (p_slow_limits) else $error("slow divider limits wrong"); // R2

    property p_slew_limits;
        (periodStart && mapIf.divSel != DIV_FASTEST && mapIf.slewEn)
            |=> dMin_r == 7'h07 && dMax_r == 7'h5D;
    endproperty
    a_slew_limits: assert property (p_slew_limits) else $error("slew limits wrong"); // R3

    property p_code_map;
        (periodStart && mapIf.voltMode)
            |=> duty_r == (($past(mapIf.code) == 7'h00) ? 7'h00
                : ($past(mapIf.code) >= 7'h64) ? 7'h64
                : ($past(mapIf.code) < dMin_r) ? dMin_r
                : ($past(mapIf.code) >= dMax_r) ? dMax_r : $past(mapIf.code));
    endproperty
    a_code_map: assert property (p_code_map) else $error("voltage duty mapping wrong"); // R6

    property p_volt_pwm;
        (ce && state_r != SDT_IDLE && modeLat_r && !periodStart)
            |=> lowSideOn == ($past(slot_r) < $past(duty_r));
    endproperty
    a_volt_pwm: assert property (p_volt_pwm) else $error("voltage pwm output wrong"); // R4

    property p_mode_reset;
        $rose(rst_n) |-> !modeSel_r && !modeLat_r;
    endproperty
    a_mode_reset: assert property (p_mode_reset) else $error("mode not current loop at reset"); // R7

    property p_hold_high;
        (ce && state_r != SDT_IDLE && holdHigh_r && !periodStart)
            |=> highSideOn && !lowSideOn;
    endproperty
    a_hold_high: assert property (p_hold_high) else $error("code zero not holding high side"); // R11

    property p_hold_low;
        (ce && state_r != SDT_IDLE && holdLow_r && !periodStart)
            |=> lowSideOn && !highSideOn;
    endproperty
    a_hold_low: assert property (p_hold_low) else $error("code top not holding low side"); // R12

    property p_period_lead;
        s_period_begin ##0 active_r ##1 (active_r && ce) |-> s_low_side_leads;
    endproperty
    a_period_lead: assert property (p_period_lead) else $error("low side not on at period start"); // R16

    property p_sustain_entry;
        $rose(state_r == SDT_SUSTAIN) |-> $past(periodStart);
    endproperty
    a_sustain_entry: assert property (p_sustain_entry) else $error("sustain entered mid period"); // R15

    property p_hold_settings;
        !periodStart |=> $stable(duty_r) && $stable(divLat_r) && $stable(modeLat_r);
    endproperty
    a_hold_settings: assert property (p_hold_settings) else $error("setting changed mid period"); // R17
endmodule : sdt_channel_core

// file: src/sdt_pkg.sv
// sdt_pkg: constants, register map and types of the solenoid duty target block
// assumes a 125 MHz system clock and one half-bridge channel per core
package sdt_pkg;
    // clock and oscillator rates
    localparam int CLK_HZ = 125_000_000;
    localparam int OSC_FAST_HZ = 100_000;
    localparam int OSC_SLOW_HZ = 80_000;
    // percent-slot tick: 100 slots per oscillator period, exact by accumulation
    localparam int TICK_W = 17;
    localparam logic [TICK_W-1:0] TICK_MOD = TICK_W'(CLK_HZ / 1000);
    localparam logic [TICK_W-1:0] TICK_STEP_FAST = TICK_W'(OSC_FAST_HZ / 10);
    localparam logic [TICK_W-1:0] TICK_STEP_SLOW = TICK_W'(OSC_SLOW_HZ / 10);
    // chop period layout
    localparam logic [6:0] SLOT_LAST = 7'h63;
    localparam logic [1:0] DIV_FASTEST = 2'h3;
    localparam logic [1:0] SUB_TOP = 2'h3;
    // duty limits in percent
    localparam logic [6:0] DUTY_MIN_FAST = 7'h08;
    localparam logic [6:0] DUTY_MAX_FAST = 7'h5C;
    localparam logic [6:0] DUTY_MIN_SLOW = 7'h04;
    localparam logic [6:0] DUTY_MAX_SLOW = 7'h60;
    localparam logic [6:0] DUTY_MIN_SLEW = 7'h07;
    localparam logic [6:0] DUTY_MAX_SLEW = 7'h5D;
    localparam logic [6:0] DUTY_ZERO = 7'h00;
    localparam logic [6:0] DUTY_FULL = 7'h64;
    localparam logic [6:0] CODE_ZERO = 7'h00;
    localparam logic [6:0] CODE_TOP = 7'h7F;
    // excite time: one unit is this many chop periods
    localparam int EXCITE_UNIT_PERIODS = 40;
    localparam logic [7:0] EXCITE_NONE = 8'h00;
    localparam logic [7:0] EXCITE_ENDLESS = 8'hFF;
    // register byte offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_LEVEL = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;
    localparam logic [3:0] OFS_THRESH = 4'hC;
    // control fields
    localparam int CTRL_ACTIVE = 0;
    localparam int CTRL_MODE = 1;
    localparam int CTRL_SLEW = 2;
    localparam int CTRL_DIV_LO = 3;
    localparam int CTRL_RATE = 5;
    // level fields
    localparam int LVL_EXCITE_LO = 0;
    localparam int LVL_SUSTAIN_LO = 8;
    localparam int LVL_TIME_LO = 16;
    // status fields
    localparam int STS_LS = 7;
    localparam int STS_HS = 8;
    localparam int STS_PHASE_LO = 9;
    localparam int STS_TRIP = 12;
    // reset values
    localparam logic [1:0] RST_DIV = 2'h3;
    localparam logic [6:0] RST_CODE = 7'h00;
    localparam logic [7:0] RST_TIME = 8'h00;

    typedef enum logic [2:0] {
        SDT_IDLE = 3'b001,
        SDT_EXCITE = 3'b010,
        SDT_SUSTAIN = 3'b100
    } sdt_phase_t;
endpackage : sdt_pkg

// file: src/sdt_map_if.sv
// sdt_map_if: level code and settings out to the duty mapper, limits back
// assumes the mapper is purely combinational
`timescale 1ns/10ps
interface sdt_map_if;
    logic [6:0] code;
    logic voltMode;
    logic slewEn;
    logic [1:0] divSel;
    logic [6:0] duty;
    logic [6:0] dutyMin;
    logic [6:0] dutyMax;
    logic [6:0] thresh;
    logic holdHigh;
    logic holdLow;

    modport core (output code, voltMode, slewEn, divSel,
                  input duty, dutyMin, dutyMax, thresh, holdHigh, holdLow);
    modport mapper (input code, voltMode, slewEn, divSel,
                    output duty, dutyMin, dutyMax, thresh, holdHigh, holdLow);
endinterface : sdt_map_if

// file: src/sdt_osc_tick.sv
// sdt_osc_tick: one pulse per percent of the oscillator period
// assumes clk at CLK_HZ; accumulation keeps the average rate exact
`timescale 1ns/10ps
module sdt_osc_tick (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // rate select and tick
    input wire logic rateSel,
    output logic tick
);
    import sdt_pkg::*;

    logic [TICK_W-1:0] acc_r;
    logic [TICK_W-1:0] step;
    logic [TICK_W:0] sum;

    assign step = rateSel ? TICK_STEP_SLOW : TICK_STEP_FAST;
    assign sum = {1'b0, acc_r} + {1'b0, step};

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_r <= '0;
            tick <= 1'b0;
        end
        else if (ce)
        begin
            if (sum >= {1'b0, TICK_MOD})
            begin
                acc_r <= TICK_W'(sum - {1'b0, TICK_MOD});
                tick <= 1'b1;
            end
            else
            begin
                acc_r <= sum[TICK_W-1:0];
                tick <= 1'b0;
            end
        end
    end
endmodule : sdt_osc_tick

// file: src/sdt_duty_map.sv
// sdt_duty_map: level code to duty, duty limits and peak threshold
// assumes settings are latched by the caller at a period boundary
`timescale 1ns/10ps
module sdt_duty_map (
    // mapping port
    sdt_map_if.mapper m
);
    import sdt_pkg::*;

    logic fast;
    logic [6:0] lo;
    logic [6:0] hi;

    assign fast = (m.divSel == DIV_FASTEST);

    always_comb
    begin
        // slew limiting has no meaning at the fastest divider, so it is ignored there
        if (fast)
        begin
            lo = DUTY_MIN_FAST; // R1
            hi = DUTY_MAX_FAST; // R1
        end
        else if (m.slewEn)
        begin
            lo = DUTY_MIN_SLEW; // R3
            hi = DUTY_MAX_SLEW; // R3
        end
        else
        begin
            lo = DUTY_MIN_SLOW; // R2
            hi = DUTY_MAX_SLOW; // R2
        end
    end

    always_comb
    begin
        if (m.code == CODE_ZERO)
            m.duty = DUTY_ZERO; // R6
        else if (m.code < lo)
            m.duty = lo; // R6
        else if (m.code < hi)
            m.duty = m.code; // R5
        else if (m.code < DUTY_FULL)
            m.duty = hi; // R6
        else
            m.duty = DUTY_FULL; // R6
    end

    assign m.dutyMin = lo;
    assign m.dutyMax = hi;
    assign m.thresh = m.voltMode ? CODE_ZERO : m.code; // R9
    assign m.holdHigh = !m.voltMode && (m.code == CODE_ZERO); // R11
    assign m.holdLow = !m.voltMode && (m.code == CODE_TOP); // R12
endmodule : sdt_duty_map

// file: verification/sdt_coil_model.sv
// sdt_coil_model: behavioural coil load behind the channel's lossless current sense
// assumes bridge switches driven synchronous to clk; one sense step per clock
`timescale 1ns/10ps
module sdt_coil_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // bridge switches
    input wire logic lowSideOn,
    input wire logic highSideOn,
    // sensed current, 128 = full scale
    output logic [7:0] senseCurrent
);
    logic [7:0] curLevel_r;

    assign senseCurrent = curLevel_r;

    // fast ramp so a trip lands well inside one chop period
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            curLevel_r <= 8'h00;
        else if (lowSideOn && !highSideOn && curLevel_r != 8'hFF)
            curLevel_r <= curLevel_r + 8'h01;
        else if (!lowSideOn && curLevel_r != 8'h00)
            curLevel_r <= curLevel_r - 8'h01;
    end
endmodule : sdt_coil_model

// file: verification/sdt_channel_core_tb_top.sv
// sdt_channel_core_tb_top: self-checking bench of one channel core
// assumes the coil model as load and an Avalon-MM master with one request at a time
`timescale 1ns/10ps
module sdt_channel_core_tb_top;
    import sdt_pkg::*;
    typedef struct {logic [7:0] ctrl; logic [6:0] code; logic [3:0] addr; logic [6:0] exp;} sdt_row_t;
    logic clk, rst_n, ce, avs_read, avs_write, avs_waitrequest, lowSideOn, highSideOn;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [7:0] senseCurrent;
    logic [6:0] peakCurrentThreshold;
    int failCount = 0;
    int numChecks = 0;
    int cyc = 0;
    int n;
    // current-mode rows model a low-side channel only
    sdt_row_t rows[15] = '{
        '{8'h1B, 7'h00, OFS_STATUS, 7'h00}, '{8'h1B, 7'h03, OFS_STATUS, 7'h08},
        '{8'h1B, 7'h32, OFS_STATUS, 7'h32}, '{8'h1B, 7'h5F, OFS_STATUS, 7'h5C},
        '{8'h1B, 7'h64, OFS_STATUS, 7'h64}, '{8'h1B, 7'h7F, OFS_STATUS, 7'h64},
        '{8'h13, 7'h03, OFS_STATUS, 7'h04}, '{8'h13, 7'h61, OFS_STATUS, 7'h60},
        '{8'h07, 7'h05, OFS_STATUS, 7'h07}, '{8'h07, 7'h5E, OFS_STATUS, 7'h5D},
        '{8'h1F, 7'h05, OFS_STATUS, 7'h08}, '{8'h3B, 7'h03, OFS_STATUS, 7'h08},
        '{8'h19, 7'h01, OFS_THRESH, 7'h01}, '{8'h19, 7'h40, OFS_THRESH, 7'h40},
        '{8'h01, 7'h7E, OFS_THRESH, 7'h7E}};

    sdt_channel_core #(.EXCITE_UNIT(1)) DUT (.clk(clk), .rst_n(rst_n), .ce(ce),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .senseCurrent(senseCurrent), .lowSideOn(lowSideOn), .highSideOn(highSideOn),
        .peakCurrentThreshold(peakCurrentThreshold));
    sdt_coil_model coil (.clk(clk), .rst_n(rst_n), .lowSideOn(lowSideOn),
        .highSideOn(highSideOn), .senseCurrent(senseCurrent));

    always #4 clk = ~clk;

    task end_sim;
        $display("checks %0d mismatches %0d", numChecks, failCount);
        if (failCount == 0 && numChecks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim

    // whole run is near 9000 cycles; the ceiling leaves room for slow answers
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            failCount++;
            end_sim();
        end
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp)
        begin
            failCount++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        int k = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (avs_waitrequest !== 1'b0 && k < 50);
        if (k >= 50)
            failCount++;
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    // settings only land at a period start, so stop the channel first to get one at once
    task run(input logic [7:0] ctrl, input logic [23:0] lvl);
        bus(1'b1, OFS_CTRL, {24'h0, ctrl & 8'hFE}, q);
        bus(1'b1, OFS_LEVEL, {8'h00, lvl}, q);
        bus(1'b1, OFS_CTRL, {24'h0, ctrl}, q);
        repeat (4) @(posedge clk);
    endtask : run

    task hold(input logic [1:0] exp);
        repeat (15)
        begin
            repeat (100) @(negedge clk);
            chk({lowSideOn, highSideOn}, exp);
        end
    endtask : hold

    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        ce = 1'b1;
        avs_byteenable = 4'hF;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b0, OFS_CTRL, 32'h0, q);
        chk(q, 32'h18);
        bus(1'b0, OFS_LEVEL, 32'h0, q);
        chk(q, 32'h0);
        bus(1'b1, OFS_THRESH, 32'h7F, q);
        bus(1'b0, 4'h2, 32'h0, q);
        chk(q, 32'h0);
        bus(1'b0, OFS_THRESH, 32'h0, q);
        chk(q, 32'h0);
        foreach (rows[i])
        begin
            run(rows[i].ctrl, {8'hFF, 1'b0, rows[i].code, 1'b0, rows[i].code});
            bus(1'b0, rows[i].addr, 32'h0, q);
            chk(q[6:0], rows[i].exp);
            if (rows[i].addr == OFS_THRESH)
                chk(peakCurrentThreshold, rows[i].exp);
        end
        run(8'h19, 24'hFF0000);
        hold(2'b01);
        run(8'h19, 24'hFF7F7F);
        hold(2'b10);
        // drain the coil so the trip point shows the threshold, not leftovers
        bus(1'b1, OFS_CTRL, 32'h18, q);
        repeat (300) @(posedge clk);
        run(8'h19, 24'hFF7878);
        n = 0;
        while (highSideOn !== 1'b1 && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
        chk(senseCurrent >= 8'h78 && senseCurrent < 8'h80, 1'b1);
        n = 0;
        while (lowSideOn !== 1'b1 && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
        chk(highSideOn, 1'b0);
        run(8'h1B, 24'h013C1E);
        bus(1'b0, OFS_STATUS, 32'h0, q);
        chk(q[11:0], 12'h49E);
        repeat (2600) @(posedge clk);
        bus(1'b0, OFS_STATUS, 32'h0, q);
        chk(q[11:9], 3'h4);
        chk(q[6:0], 7'h3C);
        bus(1'b1, OFS_LEVEL, 32'h0001461E, q);
        bus(1'b0, OFS_STATUS, 32'h0, q);
        chk(q[6:0], 7'h3C);
        repeat (1300) @(posedge clk);
        bus(1'b0, OFS_STATUS, 32'h0, q);
        chk(q[6:0], 7'h46);
        bus(1'b1, OFS_CTRL, 32'h1A, q);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({lowSideOn, highSideOn}, 2'b00);
        end_sim();
    end
endmodule : sdt_channel_core_tb_top
